// ### hdl/ext_bus_engine.sv
// bus cycle engine: byte demultiplexed instruction fetch and word-mode table write
`timescale 1ns/1ps
`default_nettype none
module ext_bus_engine
    import ext_bus_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_fetch_req,
    input wire logic [ADDR_W-1:0] i_fetch_addr,
    input wire logic i_twrite_req,
    input wire logic [ADDR_W-1:0] i_table_pointer,
    input wire logic [7:0] i_table_data_latch,
    input wire logic [7:0] i_fetch_data_port,
    output logic o_busy,
    output logic o_instr_valid,
    output logic [15:0] o_instr_word,
    output logic [3:0] o_addr_upper,
    output logic [15:0] o_addr_low,
    output logic [15:0] o_ad_out,
    output logic o_ad_oe,
    output logic o_byte_addr_lsb,
    output logic o_read_enable_n,
    output logic o_addr_latch_strobe,
    output logic o_write_strobe_high_n,
    output logic o_write_strobe_low_n,
    output logic o_upper_byte_select_n,
    output logic o_lower_byte_select_n
);
    typedef struct packed {
        cyc_t cyc;
        logic [QUARTER_W-1:0] qtr;
        logic [ADDR_W-1:0] addr;
        logic [7:0] tdata;
        logic [7:0] hold;
        logic [7:0] first_byte;
        logic [7:0] fd1;
        logic [7:0] fd2;
        logic instr_valid;
        logic [15:0] instr_word;
        logic [15:0] ad_out;
        logic ad_oe;
        logic lsb;
        logic oe_n;
        logic wrh_n;
        logic ubsel_n;
        logic lbsel_n;
    } state_t;

    state_t s_q;
    state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.fd1 = i_fetch_data_port;
        s_d.fd2 = s_q.fd1;
        s_d.instr_valid = 1'b0;
        s_d.qtr = s_q.qtr + 2'h1;
        case (s_q.cyc)
            CYC_IDLE: begin
                s_d.qtr = Q1;
                s_d.oe_n = 1'b1;
                s_d.wrh_n = 1'b1;
                s_d.ad_oe = 1'b0;
                s_d.ubsel_n = 1'b1;
                s_d.lbsel_n = 1'b1;
                if (i_fetch_req) begin
                    // address is frozen for the whole cycle
                    s_d.cyc = CYC_FETCH;
                    s_d.addr = i_fetch_addr;
                    s_d.lsb = 1'b0;
                    s_d.oe_n = 1'b0;
                end else if (i_twrite_req) begin
                    s_d.cyc = CYC_TWRITE;
                    s_d.addr = i_table_pointer;
                    s_d.tdata = i_table_data_latch;
                    s_d.lsb = i_table_pointer[0];
                end
            end
            CYC_FETCH: begin
                // input data sampled through two flops, so bytes are taken two quarters late
                // lsb moves after the first quarter so the second byte clears both flops in time
                if (s_q.qtr == Q1) begin
                    s_d.lsb = 1'b1;
                end
                if (s_q.qtr == Q3) begin
                    s_d.first_byte = s_q.fd2;
                end
                if (s_q.qtr == Q4) begin
                    s_d.oe_n = 1'b1;
                    s_d.cyc = CYC_IDLE;
                    s_d.instr_valid = 1'b1;
                    // only the second flop is read, the first may still be settling
                    s_d.instr_word = {s_q.fd2, s_q.first_byte};
                end
            end
            CYC_TWRITE: begin
                if (s_q.qtr == Q1) begin
                    // address phase drives the low address on the multiplexed bus
                    s_d.ad_out = s_q.addr[15:0];
                    s_d.ad_oe = 1'b1;
                end
                if (s_q.qtr == Q2) begin
                    if (!s_q.addr[0]) begin
                        s_d.hold = s_q.tdata;
                        s_d.ad_oe = 1'b0;
                    end else begin
                        s_d.ad_out = {s_q.tdata, s_q.hold};
                        s_d.ubsel_n = 1'b0;
                        s_d.lbsel_n = 1'b0;
                        s_d.wrh_n = 1'b0;
                    end
                end
                if (s_q.qtr == Q3) begin
                    s_d.wrh_n = 1'b1;
                end
                if (s_q.qtr == Q4) begin
                    s_d.cyc = CYC_IDLE;
                    s_d.ad_oe = 1'b0;
                    s_d.ubsel_n = 1'b1;
                    s_d.lbsel_n = 1'b1;
                end
            end
            default: s_d.cyc = CYC_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_q <= '{cyc: CYC_IDLE, qtr: Q1, addr: '0, tdata: BYTE_RESET, hold: BYTE_RESET,
                     first_byte: BYTE_RESET, fd1: BYTE_RESET, fd2: BYTE_RESET, instr_valid: 1'b0,
                     instr_word: WORD_RESET, ad_out: WORD_RESET, ad_oe: 1'b0, lsb: 1'b0,
                     oe_n: 1'b1, wrh_n: 1'b1, ubsel_n: 1'b1, lbsel_n: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_busy = (s_q.cyc != CYC_IDLE);
    assign o_instr_valid = s_q.instr_valid;
    assign o_instr_word = s_q.instr_word;
    assign o_addr_upper = s_q.addr[19:16];
    assign o_addr_low = s_q.addr[15:0];
    assign o_ad_out = s_q.ad_out;
    assign o_ad_oe = s_q.ad_oe;
    assign o_byte_addr_lsb = s_q.lsb;
    assign o_read_enable_n = s_q.oe_n;
    // nobody outside latches addresses in this mode, strobe held low
    assign o_addr_latch_strobe = 1'b0;
    assign o_write_strobe_high_n = s_q.wrh_n;
    assign o_write_strobe_low_n = 1'b1;
    assign o_upper_byte_select_n = s_q.ubsel_n;
    assign o_lower_byte_select_n = s_q.lbsel_n;

    fetch_addr_stable_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (s_q.cyc == CYC_FETCH && s_q.qtr != Q4) |=> $stable(o_addr_low) && $stable(o_addr_upper))
        else $error("fetch address moved inside the cycle");
    fetch_two_bytes_a: assert property (@(posedge i_clk) disable iff (i_srst)
        ($rose(o_busy) && !o_read_enable_n) |-> ##4 o_instr_valid)
        else $error("fetch did not finish within one instruction cycle");
    lsb_toggle_a: assert property (@(posedge i_clk) disable iff (i_srst)
        ($rose(o_busy) && !o_read_enable_n) |-> !o_byte_addr_lsb ##1 o_byte_addr_lsb)
        else $error("byte address lsb did not toggle mid fetch");
    even_no_strobe_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (s_q.cyc == CYC_TWRITE && !s_q.addr[0]) |-> o_write_strobe_high_n)
        else $error("write strobe on an even table write");
    odd_bus_data_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !o_write_strobe_high_n |-> o_ad_oe && o_ad_out == {s_q.tdata, s_q.hold})
        else $error("odd write data misplaced");
    low_strobe_idle_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_write_strobe_low_n) else $error("low write strobe asserted");
    both_selects_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !o_write_strobe_high_n |-> !o_upper_byte_select_n && !o_lower_byte_select_n)
        else $error("byte selects not both active");
    lsb_is_ptr_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (s_q.cyc == CYC_TWRITE) |-> o_byte_addr_lsb == s_q.addr[0])
        else $error("byte address lsb differs from pointer bit 0");
    upper_addr_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_busy |-> o_addr_upper == s_q.addr[19:16])
        else $error("upper address lines wrong");

    // fetch cycle shape
    fetch_oe_active_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (s_q.cyc == CYC_FETCH) |-> !o_read_enable_n)
        else $error("read enable inactive inside a fetch");
    fetch_lsb_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (s_q.cyc == CYC_FETCH && s_q.qtr != Q4 && o_byte_addr_lsb) |=> o_byte_addr_lsb)
        else $error("byte address lsb fell back inside a fetch");
    fetch_bus_quiet_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (s_q.cyc == CYC_FETCH) |-> o_write_strobe_high_n && o_upper_byte_select_n && o_lower_byte_select_n && !o_ad_oe)
        else $error("multiplexed bus active during a fetch");
    valid_one_cycle_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_instr_valid |=> !o_instr_valid)
        else $error("instruction valid longer than one cycle");
    upper_addr_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (o_busy && !$rose(o_busy)) |-> $stable(o_addr_upper))
        else $error("upper address moved inside a bus cycle");

    // table write shape
    write_pulse_once_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !o_write_strobe_high_n |=> o_write_strobe_high_n)
        else $error("write strobe longer than one cycle");
    odd_write_pulse_a: assert property (@(posedge i_clk) disable iff (i_srst)
        ($rose(o_busy) && s_q.cyc == CYC_TWRITE && s_q.addr[0]) |-> ##2 !o_write_strobe_high_n)
        else $error("odd table write gave no write strobe");
    odd_select_span_a: assert property (@(posedge i_clk) disable iff (i_srst)
        ($rose(o_busy) && s_q.cyc == CYC_TWRITE && s_q.addr[0]) |->
        ##2 (!o_upper_byte_select_n && !o_lower_byte_select_n) ##1 (!o_upper_byte_select_n && !o_lower_byte_select_n))
        else $error("byte selects dropped inside the odd data phase");
    write_addr_phase_a: assert property (@(posedge i_clk) disable iff (i_srst)
        ($rose(o_busy) && s_q.cyc == CYC_TWRITE) |=> o_ad_oe && o_ad_out == o_addr_low)
        else $error("table write address phase missing");
    even_bus_float_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (s_q.cyc == CYC_TWRITE && !s_q.addr[0] && (s_q.qtr == Q3 || s_q.qtr == Q4)) |-> !o_ad_oe)
        else $error("bus driven in an even data phase");
    hold_load_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (s_q.cyc == CYC_TWRITE && !s_q.addr[0] && s_q.qtr == Q2) |=> s_q.hold == $past(s_q.tdata))
        else $error("holding latch did not take the even byte");
    // the latch may only move on an even data phase, so a fetch between the pair cannot disturb it
    hold_kept_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !(s_q.cyc == CYC_TWRITE && !s_q.addr[0] && s_q.qtr == Q2) |=> $stable(s_q.hold))
        else $error("holding latch changed outside an even data phase");
endmodule
`default_nettype wire

// ### hdl/ext_bus_pkg.sv
// constants and types for the external bus fetch and table write engine
// What this block does
// - in byte demultiplexed fetch mode address and data leave on separate pin groups, no latch needed outside.
// - each instruction is read as two byte reads on the fetch data port within one instruction cycle.
// - the fetch address stays stable on the address bus for the whole fetch cycle.
// - read enable stays active across both bytes; byte_addr_lsb toggles after the first byte and the second byte is read into a 16-bit word.
// - a word-mode table write behaves differently for an even and an odd table_pointer.
// - an even table write copies table_data_latch into the holding latch, floats the bus data phase, no strobe.
// - an odd table write drives table_data_latch on the upper bus byte and the holding latch on the lower byte.
// - in word write mode only write_strobe_high pulses; write_strobe_low stays inactive.
// - during the data phase of an odd word-mode write both upper_byte_select and lower_byte_select are active; an even write leaves both inactive.
// - in word write mode byte_addr_lsb shows table_pointer bit 0.
package ext_bus_pkg;
    localparam int ADDR_W = 20;
    localparam int QUARTER_W = 2;
    // one instruction cycle is four core quarters
    localparam logic [QUARTER_W-1:0] Q1 = 2'h0;
    localparam logic [QUARTER_W-1:0] Q2 = 2'h1;
    localparam logic [QUARTER_W-1:0] Q3 = 2'h2;
    localparam logic [QUARTER_W-1:0] Q4 = 2'h3;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    typedef enum logic [1:0] {
        CYC_IDLE,
        CYC_FETCH,
        CYC_TWRITE
    } cyc_t;
endpackage

// ### dv/ext_mem_model.sv
// external byte memory: answers fetch reads and stores word writes
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
    input wire logic i_clk,
    input wire logic [15:0] i_addr_low,
    input wire logic i_lsb,
    input wire logic i_oe_n,
    input wire logic [15:0] i_ad,
    input wire logic i_wrh_n,
    input wire logic i_ub_n,
    input wire logic i_lb_n,
    output logic [7:0] o_data
);
    logic [7:0] mem [256];
    logic [7:0] last;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'hA5 ^ i[7:0];
        last = 8'h00;
    end
    // released port shows the inverse of the last byte, never a stale match
    always_comb o_data = !i_oe_n ? mem[{i_addr_low[7:1], i_lsb}] : ~last;
    always @(posedge i_clk) begin
        if (!i_oe_n) last <= o_data;
        if (!i_wrh_n && !i_ub_n && !i_lb_n) begin
            mem[{i_addr_low[7:1], 1'b0}] <= i_ad[7:0];
            mem[{i_addr_low[7:1], 1'b1}] <= i_ad[15:8];
        end
    end
endmodule
`default_nettype wire

// ### dv/external_memory_bus_fetch_write_test.sv
// self-checking bench for the fetch and word-mode table write engine
`timescale 1ns/1ps
`default_nettype none
module external_memory_bus_fetch_write_test;
    import ext_bus_pkg::*;
    logic i_clk = 0, i_srst = 1, i_fetch_req = 0, i_twrite_req = 0;
    logic [ADDR_W-1:0] i_fetch_addr = '0, i_table_pointer = '0;
    logic [7:0] i_table_data_latch = 8'h00, hold = 8'h00;
    wire logic [7:0] port;
    wire logic busy, valid, ale, lsb, oe_n, ad_oe, wrh_n, wrl_n, ub_n, lb_n;
    wire logic [15:0] word, alow, ad;
    wire logic [3:0] aup;
    logic [7:0] ref_mem [256];
    int miscompares = 0, total_checks = 0;
    ext_bus_engine dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_fetch_req(i_fetch_req), .i_fetch_addr(i_fetch_addr),
        .i_twrite_req(i_twrite_req), .i_table_pointer(i_table_pointer), .i_table_data_latch(i_table_data_latch),
        .i_fetch_data_port(port), .o_busy(busy), .o_instr_valid(valid), .o_instr_word(word), .o_addr_upper(aup),
        .o_addr_low(alow), .o_ad_out(ad), .o_ad_oe(ad_oe), .o_byte_addr_lsb(lsb), .o_read_enable_n(oe_n),
        .o_addr_latch_strobe(ale), .o_write_strobe_high_n(wrh_n), .o_write_strobe_low_n(wrl_n),
        .o_upper_byte_select_n(ub_n), .o_lower_byte_select_n(lb_n));
    ext_mem_model mem_u (.i_clk(i_clk), .i_addr_low(alow), .i_lsb(lsb), .i_oe_n(oe_n), .i_ad(ad),
        .i_wrh_n(wrh_n), .i_ub_n(ub_n), .i_lb_n(lb_n), .o_data(port));
    always #25 i_clk = ~i_clk;
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task do_fetch(input logic [19:0] a);
        int n;
        logic ok;
        i_fetch_addr = a;
        i_fetch_req = 1;
        @(posedge i_clk);
        #1 i_fetch_req = 0;
        n = 0;
        ok = 1;
        while (valid !== 1'b1 && n < 8) begin
            if (busy === 1'b1 && (alow !== a[15:0] || aup !== a[19:16] || oe_n !== 1'b0)) ok = 0;
            @(posedge i_clk);
            #1 n++;
        end
        chk("fetch_done_in_time", 16'h1, {15'h0, valid === 1'b1 && n <= 5});
        chk("fetch_word", {ref_mem[{a[7:1], 1'b1}], ref_mem[{a[7:1], 1'b0}]}, word);
        chk("fetch_addr_stable", 16'h1, {15'h0, ok});
        chk("read_enable_released", 16'h1, {15'h0, oe_n});
        chk("latch_strobe", 16'h0, {15'h0, ale});
    endtask
    task do_twrite(input logic [19:0] p, input logic [7:0] d);
        int pulses;
        logic ok, last_oe;
        i_table_pointer = p;
        i_table_data_latch = d;
        i_twrite_req = 1;
        @(posedge i_clk);
        #1 i_twrite_req = 0;
        pulses = 0;
        ok = 1;
        last_oe = 1;
        repeat (6) begin
            if (busy === 1'b1) begin
                if (lsb !== p[0] || aup !== p[19:16]) ok = 0;
                last_oe = ad_oe;
            end
            if (wrl_n !== 1'b1) ok = 0;
            if (wrh_n === 1'b0) begin
                pulses++;
                if (ad !== {d, hold} || ad_oe !== 1'b1 || ub_n !== 1'b0 || lb_n !== 1'b0) ok = 0;
            end
            @(posedge i_clk);
            #1;
        end
        chk("twrite_lines", 16'h1, {15'h0, ok});
        chk("wrh_pulses", {15'h0, p[0]}, pulses[15:0]);
        if (!p[0]) begin
            chk("even_data_float", 16'h0, {15'h0, last_oe});
            hold = d;
        end else begin
            ref_mem[{p[7:1], 1'b0}] = hold;
            ref_mem[{p[7:1], 1'b1}] = d;
        end
    endtask
    task reset_mid_fetch(input logic [19:0] a);
        i_fetch_addr = a;
        i_fetch_req = 1;
        @(posedge i_clk);
        #1 i_fetch_req = 0;
        @(posedge i_clk);
        #1 i_srst = 1;
        @(posedge i_clk);
        #1 i_srst = 0;
        hold = 8'h00;
        chk("mid_reset_idle", 16'h000F, {10'h0, busy, ad_oe, oe_n, wrh_n, ub_n, lb_n});
        repeat (4) begin
            @(posedge i_clk);
            #1 chk("mid_reset_no_valid", 16'h0, {15'h0, valid});
        end
    endtask
    initial begin
        #(50 * 400);
        miscompares++;
        report_and_stop();
    end
    initial begin
        for (int i = 0; i < 256; i++) ref_mem[i] = 8'hA5 ^ i[7:0];
        repeat (5) @(posedge i_clk);
        #1 i_srst = 0;
        chk("reset_idle", 16'h000F, {10'h0, busy, ad_oe, oe_n, wrh_n, ub_n, lb_n});
        do_fetch(20'h07554);
        // back to back: the second request follows the first answer directly
        do_fetch(20'h07556);
        do_twrite(20'h99E66, 8'h56);
        // fetch between the pair must see memory untouched and keep the held byte
        do_fetch(20'h99E66);
        do_twrite(20'h99E67, 8'h92);
        reset_mid_fetch(20'h07558);
        do_fetch(20'h99E66);
        report_and_stop();
    end
endmodule
`default_nettype wire
